// ### bci_cfg.svh
// constants for the buffer channel interface of an external equipment
//----------------------------------------------------------------------
// Function
// R1 - computer drives twelve function lines
// R2 - function lines shared; equipment checks own code
// R3 - channels one to seven, odd input
// R4 - select, buffer start, sense roles distinguished
// R5 - buffer words are forty-eight bits
// R6 - computer raises exactly one ready strobe
// R7 - equipment never acknowledges a function code
// R8 - sense response only when condition present
// R9 - interrupt on completion once select enabled
// R10 - computer keeps per-channel buffer control word
// R11 - three storage references per buffered word
// R12 - input buffer active starts selected equipment
// R13 - equipment packs words, waits input resume
// R14 - input active drop clears equipment control
// R15 - equipment unpacks output word, returns resume
// R16 - output active drop halts and clears equipment
// R17 - computer scanner visits channels cyclically
// R18 - worst service within 200 microseconds
// R19 - computer should sense before select
// R20 - upper three bits equipment, lower nine operation
// R21 - sample only under strobe; hold select
//----------------------------------------------------------------------
`ifndef BCI_CFG_SVH
`define BCI_CFG_SVH

// function code layout
`define BCI_FN_W        12
`define BCI_EQ_MSB      11
`define BCI_EQ_LSB      9
`define BCI_OP_MSB      8
`define BCI_OP_LSB      0
`define BCI_OP_W        9
// sense condition index sits in the low bits of the operation field
`define BCI_SNS_IDX_W   3
`define BCI_SNS_HI_MSB  8
`define BCI_SNS_HI_LSB  3

// operation that arms the completion interrupt
`define BCI_OP_INT_EN   9'h004

// word and character layout
`define BCI_WORD_W      48
`define BCI_CHAR_W      6

// reset values
`define BCI_OP_RST      9'h000
`define BCI_EQ_RST      3'h0

`endif

// ### bci_pkg.sv
// types shared by the buffer channel interface files
`include "bci_cfg.svh"

package bci_pkg;

    // output word disassembly states
    typedef enum logic {
        BCI_OUT_IDLE,
        BCI_OUT_SHIFT
    } bci_ostate_t;

endpackage : bci_pkg

// ### bci_word_asm.sv
// character-to-word assembler for the input channel
`timescale 1ns/100ps
`default_nettype none
`include "bci_cfg.svh"

module bci_word_asm
    import bci_pkg::*;
#(
    parameter int WORD_W = `BCI_WORD_W,
    parameter int CHAR_W = `BCI_CHAR_W
) (
    input  wire logic              mclk,        // system clock
    input  wire logic              rst_n,       // sync reset, active low
    input  wire logic              enable,      // input buffer active
    input  wire logic [CHAR_W-1:0] char_in,     // character from the medium
    input  wire logic              char_valid,  // character offered
    output var  logic              char_ready,  // character can be taken
    input  wire logic              word_take,   // computer stored the word
    output var  logic [WORD_W-1:0] word,        // assembled word
    output var  logic              word_full    // word presented
);

    localparam int CHARS = WORD_W / CHAR_W;
    localparam int CNT_W = $clog2(CHARS + 1);

    logic [CNT_W-1:0] count;

    //------------------------------------------------------------
    // next-state decode
    //------------------------------------------------------------
    wire char_take  = char_valid && char_ready;
    wire last_char  = char_take && (count == CNT_W'(CHARS - 1));
    // set wins over take so a finished word is never lost
    wire next_full  = enable && (last_char || (word_full && !word_take)); // R13
    wire next_ready = enable && !next_full;

    // shift in at the bottom so the first character ends at the top, clear on inactive
    always_ff @(posedge mclk) begin
        if (!rst_n || !enable) begin // R14
            count      <= '0;
            word       <= '0;
            word_full  <= 1'b0;
            char_ready <= 1'b0;
        end else begin
            if (char_take) begin
                word  <= {word[WORD_W-CHAR_W-1:0], char_in};
                count <= last_char ? '0 : count + CNT_W'(1);
            end
            word_full  <= next_full;  // R13
            char_ready <= next_ready; // R13
        end
    end

endmodule : bci_word_asm
`default_nettype wire

// ### bci_equip.sv
// external equipment end of a computer buffer channel
`timescale 1ns/100ps
`default_nettype none
`include "bci_cfg.svh"

module bci_equip
    import bci_pkg::*;
#(
    parameter int WORD_W = `BCI_WORD_W,
    parameter int CHAR_W = `BCI_CHAR_W
) (
    input  wire logic              mclk,              // 10 MHz clock
    input  wire logic              rst_n,             // sync reset, active low
    // function channel from the computer
    input  wire logic [11:0]       external_function_code, // shared lines
    input  wire logic              in_func_ready,     // input select strobe
    input  wire logic              out_func_ready,    // output select strobe
    input  wire logic              in_sense_ready,    // input sense strobe
    input  wire logic              out_sense_ready,   // output sense strobe
    output var  logic              sense_response,    // condition present
    output var  logic              interrupt,         // completion interrupt
    // input information channel
    input  wire logic              in_buf_active,     // input buffer active
    output var  logic [WORD_W-1:0] input_word_holding_register, // word out
    output var  logic              in_data_ready,     // word presented
    input  wire logic              in_data_resume,    // word stored
    // output information channel
    input  wire logic              out_buf_active,    // output buffer active
    input  wire logic [WORD_W-1:0] output_word_register, // word in
    input  wire logic              out_data_ready,    // word offered
    output var  logic              out_data_resume,   // word accepted
    // equipment side
    input  wire logic [2:0]        equip_code_strap,  // own selection code
    input  wire logic [7:0]        in_sense_cond,     // input-side conditions
    input  wire logic [7:0]        out_sense_cond,    // output-side conditions
    input  wire logic              op_done,           // selected op finished
    output var  logic [8:0]        sel_in_op,         // stored input select
    output var  logic [8:0]        sel_out_op,        // stored output select
    output var  logic              sel_in_new,        // input select pulse
    output var  logic              sel_out_new,       // output select pulse
    input  wire logic [CHAR_W-1:0] char_in,           // character to pack
    input  wire logic              char_in_valid,     // character offered
    output var  logic              char_in_ready,     // character taken
    output var  logic [CHAR_W-1:0] char_out,          // unpacked character
    output var  logic              char_out_valid,    // character offered
    input  wire logic              char_out_ready     // character taken
);

    localparam int CHARS = WORD_W / CHAR_W;
    localparam int CNT_W = $clog2(CHARS + 1);

    logic [2:0]        equip_code;
    logic              int_armed;
    logic [WORD_W-1:0] out_word;
    logic [CNT_W-1:0]  out_count;
    logic              out_ready_prev;
    bci_ostate_t       ostate;
    bci_ostate_t       next_ostate;

    //------------------------------------------------------------
    // function code decode
    //------------------------------------------------------------
    // strap caught by the clock, never by the reset itself
    always_ff @(posedge mclk) begin
        if (!rst_n) equip_code <= `BCI_EQ_RST;
        else        equip_code <= equip_code_strap;
    end

    // every equipment sees every code; only a match is ours
    wire [2:0] fn_eq  = external_function_code[`BCI_EQ_MSB:`BCI_EQ_LSB]; // R20
    wire [8:0] fn_op  = external_function_code[`BCI_OP_MSB:`BCI_OP_LSB]; // R20
    wire       fn_hit = (fn_eq == equip_code);                            // R2
    // lines are looked at only under a strobe
    wire sel_in_hit   = in_func_ready && fn_hit;   // R21
    wire sel_out_hit  = out_func_ready && fn_hit;  // R21
    wire sel_hit      = sel_in_hit || sel_out_hit; // R4
    wire sns_hit      = (in_sense_ready || out_sense_ready) && fn_hit; // R4
    wire [2:0] sns_idx = fn_op[`BCI_SNS_IDX_W-1:0];
    wire sns_legal    = (fn_op[`BCI_SNS_HI_MSB:`BCI_SNS_HI_LSB] == 6'h00);
    wire sns_cond     = in_sense_ready ? in_sense_cond[sns_idx]
                                       : out_sense_cond[sns_idx];
    wire next_sense   = sns_hit && sns_legal && sns_cond; // R8
    wire arm_int      = sel_hit && (fn_op == `BCI_OP_INT_EN); // R9
    wire fire_int     = op_done && int_armed;                 // R9

    //------------------------------------------------------------
    // select storage, sense answer, interrupt
    //------------------------------------------------------------
    // stored select is kept until another select replaces it; no ack is
    // ever returned for a function code, only the sense answer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sel_in_op   <= `BCI_OP_RST;
            sel_out_op  <= `BCI_OP_RST;
            sel_in_new  <= 1'b0;
            sel_out_new <= 1'b0;
        end else begin
            if (sel_in_hit)  sel_in_op  <= fn_op; // R21
            if (sel_out_hit) sel_out_op <= fn_op; // R21
            sel_in_new  <= sel_in_hit;            // R7
            sel_out_new <= sel_out_hit;           // R7
        end
    end

    // sense answer stands one cycle after the strobe, nothing otherwise
    always_ff @(posedge mclk) begin
        if (!rst_n) sense_response <= 1'b0;
        else        sense_response <= next_sense; // R8
    end

    // arming wins over the disarm caused by a firing in the same cycle;
    // the request stays until a later select clears it, set wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            int_armed <= 1'b0;
            interrupt <= 1'b0;
        end else begin
            int_armed <= arm_int || (int_armed && !fire_int);   // R9
            interrupt <= fire_int || (interrupt && !sel_hit);   // R9
        end
    end

    //------------------------------------------------------------
    // input channel: character packing
    //------------------------------------------------------------
    bci_word_asm #(
        .WORD_W (WORD_W),
        .CHAR_W (CHAR_W)
    ) u_asm (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .enable     (in_buf_active),               // R14
        .char_in    (char_in),
        .char_valid (char_in_valid),
        .char_ready (char_in_ready),
        .word_take  (in_data_resume),              // R13
        .word       (input_word_holding_register),
        .word_full  (in_data_ready)
    );

    //------------------------------------------------------------
    // output channel: word disassembly
    //------------------------------------------------------------
    // only a fresh offer is taken, so a ready still high after our
    // resume is not mistaken for a second word
    wire out_offer  = out_buf_active && out_data_ready && !out_ready_prev;
    wire out_take   = (ostate == BCI_OUT_IDLE) && out_offer;       // R15
    wire char_taken = char_out_valid && char_out_ready;
    wire out_last   = char_taken && (out_count == CNT_W'(CHARS - 1)); // R5

    always_comb begin
        next_ostate = ostate;
        case (ostate)
            BCI_OUT_IDLE:  if (out_take) next_ostate = BCI_OUT_SHIFT;
            BCI_OUT_SHIFT: if (out_last) next_ostate = BCI_OUT_IDLE;
            default:       next_ostate = BCI_OUT_IDLE;
        endcase
        if (!out_buf_active) next_ostate = BCI_OUT_IDLE; // R16
    end

    // first character leaves from the top of the word
    assign char_out = out_word[WORD_W-1 -: CHAR_W];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ostate         <= BCI_OUT_IDLE;
            out_ready_prev <= 1'b0;
        end else begin
            ostate         <= next_ostate;
            out_ready_prev <= out_data_ready;
        end
    end

    // word register, character count and the resume pulse
    always_ff @(posedge mclk) begin
        if (!rst_n || !out_buf_active) begin // R16
            out_word        <= '0;
            out_count       <= '0;
            char_out_valid  <= 1'b0;
            out_data_resume <= 1'b0;
        end else begin
            out_data_resume <= out_take; // R15
            if (out_take) begin
                out_word       <= output_word_register; // R15
                out_count      <= '0;
                char_out_valid <= 1'b1;
            end else if (char_taken) begin
                out_word       <= {out_word[WORD_W-CHAR_W-1:0], {CHAR_W{1'b0}}};
                out_count      <= out_last ? '0 : out_count + CNT_W'(1);
                char_out_valid <= !out_last;
            end
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_in_offer;
        in_buf_active && in_data_ready && !in_data_resume;
    endsequence

    sequence s_out_accept;
        out_data_resume ##1 !out_data_resume;
    endsequence

    property p_sense_cause;
        @(posedge mclk) disable iff (!rst_n)
        sense_response |-> $past(sns_hit && sns_legal);
    endproperty
    a_sense_cause: assert property (p_sense_cause) // R8
        else $error("sense response without an addressed sense strobe");

    property p_sense_true;
        @(posedge mclk) disable iff (!rst_n)
        (in_sense_ready && fn_hit && sns_legal && in_sense_cond[sns_idx])
            |=> sense_response;
    endproperty
    a_sense_true: assert property (p_sense_true) // R8
        else $error("present condition not answered");

    property p_sel_store;
        @(posedge mclk) disable iff (!rst_n)
        sel_out_hit |=> (sel_out_op == $past(fn_op)) && sel_out_new;
    endproperty
    a_sel_store: assert property (p_sel_store) // R21
        else $error("output select code not stored");

    property p_sel_hold;
        @(posedge mclk) disable iff (!rst_n)
        !in_func_ready |=> $stable(sel_in_op) && !sel_in_new;
    endproperty
    a_sel_hold: assert property (p_sel_hold) // R21
        else $error("input select changed without a strobe");

    property p_foreign;
        @(posedge mclk) disable iff (!rst_n)
        (in_func_ready && !fn_hit) |=> $stable(sel_in_op);
    endproperty
    a_foreign: assert property (p_foreign) // R20
        else $error("code for another equipment was taken");

    property p_int_fire;
        @(posedge mclk) disable iff (!rst_n)
        (op_done && int_armed) |=> interrupt ##1 (interrupt || $past(sel_hit));
    endproperty
    a_int_fire: assert property (p_int_fire) // R9
        else $error("completion interrupt not raised or dropped early");

    property p_int_cause;
        @(posedge mclk) disable iff (!rst_n)
        $rose(interrupt) |-> $past(int_armed) && $past(op_done);
    endproperty
    a_int_cause: assert property (p_int_cause) // R9
        else $error("interrupt without armed completion");

    property p_in_hold;
        @(posedge mclk) disable iff (!rst_n)
        s_in_offer |=> in_data_ready && $stable(input_word_holding_register);
    endproperty
    a_in_hold: assert property (p_in_hold) // R13
        else $error("input word withdrawn before resume");

    property p_in_clear;
        @(posedge mclk) disable iff (!rst_n)
        !in_buf_active |=> !in_data_ready && !char_in_ready;
    endproperty
    a_in_clear: assert property (p_in_clear) // R14
        else $error("input side not cleared after active dropped");

    property p_out_resume;
        @(posedge mclk) disable iff (!rst_n)
        (out_take && out_buf_active) |=> s_out_accept;
    endproperty
    a_out_resume: assert property (p_out_resume) // R15
        else $error("output resume not a single pulse after take");

    property p_out_clear;
        @(posedge mclk) disable iff (!rst_n)
        !out_buf_active |=> !char_out_valid && !out_data_resume;
    endproperty
    a_out_clear: assert property (p_out_clear) // R16
        else $error("output side not cleared after active dropped");

    property p_no_ack;
        @(posedge mclk) disable iff (!rst_n)
        (sel_hit && !out_offer) |=> !out_data_resume;
    endproperty
    a_no_ack: assert property (p_no_ack) // R7
        else $error("select answered with a resume");

endmodule : bci_equip
`default_nettype wire

// ### bci_host_model.sv
// computer i/o control model facing one external equipment
`timescale 1ns/100ps
`default_nettype none

module bci_host_model (
    input  wire logic        mclk,                        // system clock
    output var  logic [11:0] external_function_code,      // shared function lines
    output var  logic        in_func_ready,               // input select strobe
    output var  logic        out_func_ready,              // output select strobe
    output var  logic        in_sense_ready,              // input sense strobe
    output var  logic        out_sense_ready,             // output sense strobe
    input  wire logic        sense_response,              // condition present
    output var  logic        in_buf_active,               // input buffer active
    input  wire logic [47:0] input_word_holding_register, // word in
    input  wire logic        in_data_ready,               // word presented
    output var  logic        in_data_resume,              // word stored
    output var  logic        out_buf_active,              // output buffer active
    output var  logic [47:0] output_word_register,        // word out
    output var  logic        out_data_ready,              // word offered
    input  wire logic        out_data_resume              // word accepted
);
    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    localparam int IN_CH  = 1;  // odd channel buffers input
    localparam int OUT_CH = 2;  // even channel buffers output
    logic [47:0] got[$];        // words stored in computer memory

    // idle lines show the inverse of nothing in particular
    initial begin
        external_function_code = 12'hFFF;
        {in_func_ready, out_func_ready, in_sense_ready, out_sense_ready} = 4'h0;
        in_buf_active          = 1'b0;
        in_data_resume         = 1'b0;
        out_buf_active         = 1'b0;
        output_word_register   = 48'h0;
        out_data_ready         = 1'b0;
    end

    // one strobe per instruction; strb 0..3 = in fn, out fn, in sense, out sense
    task automatic func(input int strb, input logic [11:0] code, output logic resp);
        @(posedge mclk);
        #10;
        external_function_code = code;
        {in_func_ready, out_func_ready, in_sense_ready, out_sense_ready} = 4'(4'h8 >> strb);
        @(posedge mclk);
        #10;
        {in_func_ready, out_func_ready, in_sense_ready, out_sense_ready} = 4'h0;
        external_function_code = ~code;  // stale code must not be taken again
        resp = sense_response;
    endtask : func

    // input buffer run driven by a control word, one channel so no scan wait
    task automatic in_block(input logic [14:0] start, input int nwords);
        logic [14:0] cur;
        logic [14:0] term;
        int          n;
        term = start + 15'(nwords);  // terminal address plus one
        cur  = start;
        @(posedge mclk);
        #10;
        in_buf_active = 1'b1;
        while (cur != term) begin  // control word read
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (in_data_ready !== 1'b1 && n < 400);  // scanner pauses
            #10;
            got.push_back(input_word_holding_register);  // data reference
            in_data_resume = 1'b1;
            @(posedge mclk);
            #10;
            in_data_resume = 1'b0;
            cur = cur + 15'h0001;  // address write back
        end
        in_buf_active = 1'b0;
    endtask : in_block

    // input active for a few cycles only, an abandoned operation
    task automatic in_abort(input int cyc);
        @(posedge mclk);
        #10;
        in_buf_active = 1'b1;
        repeat (cyc) @(posedge mclk);
        #10;
        in_buf_active = 1'b0;
    endtask : in_abort

    // one output word; active is raised a cycle ahead of the first offer
    task automatic out_word(input logic [47:0] w);
        int n;
        @(posedge mclk);
        #10;
        if (!out_buf_active) begin
            out_buf_active = 1'b1;
            @(posedge mclk);
            #10;
        end
        output_word_register = w;
        out_data_ready       = 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (out_data_resume !== 1'b1 && n < 400);
        #10;
        out_data_ready       = 1'b0;
        output_word_register = ~w;  // word no longer held
    endtask : out_word

    // end of the output operation
    task automatic out_stop();
        @(posedge mclk);
        #10;
        out_buf_active = 1'b0;
    endtask : out_stop
endmodule : bci_host_model
`default_nettype wire

// ### bci_equip_bench.sv
// self-checking bench of the equipment end of a buffer channel
`timescale 1ns/100ps
`default_nettype none

module bci_equip_bench;
    import bci_pkg::*;
    //--------------------------------------------------------------
    // signals
    //--------------------------------------------------------------
    logic        mclk, rst_n, resp, op_done, char_in_valid, char_out_ready;
    logic        in_func_ready, out_func_ready, in_sense_ready, out_sense_ready;
    logic        sense_response, interrupt, in_buf_active, in_data_ready;
    logic        in_data_resume, out_buf_active, out_data_ready, out_data_resume;
    logic        sel_in_new, sel_out_new, char_in_ready, char_out_valid;
    logic [11:0] external_function_code;
    logic [47:0] input_word_holding_register, output_word_register, w;
    logic [7:0]  in_sense_cond, out_sense_cond;
    logic [8:0]  sel_in_op, sel_out_op;
    logic [5:0]  char_in, char_out;
    int          err_count, cmp_count, cyc;

    // every other port meets the bench signal of the same name
    bci_equip i_bci_equip (.*, .equip_code_strap(3'h2));

    bci_host_model i_bci_host_model (.*);

    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    always #50 mclk = ~mclk;

    // hang guard, far above the longest expected run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // offer characters top first; valid stays up between words and after
    task automatic feed(input logic [47:0] wd, input int nch);
        int n;
        for (int i = 0; i < nch; i++) begin
            char_in       = wd[47-6*i -: 6];
            char_in_valid = 1'b1;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (char_in_ready !== 1'b1 && n < 400);
            #10;
        end
    endtask : feed

    // take characters from the unpacker, far side always ready
    task automatic drain(input int nch, output logic [47:0] wd);
        int n;
        wd = 48'h0;
        for (int i = 0; i < nch; i++) begin
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (char_out_valid !== 1'b1 && n < 400);
            wd = {wd[41:0], char_out};
        end
        #10;
    endtask : drain

    task automatic pulse_done();
        @(posedge mclk);
        #10;
        op_done = 1'b1;
        @(posedge mclk);
        #10;
        op_done = 1'b0;
    endtask : pulse_done

    //--------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------
    task automatic t_select();
        i_bci_host_model.func(0, 12'h412, resp);
        chk(48'(resp), 48'h0);
        chk(48'({sel_in_op, sel_in_new}), 48'({9'h012, 1'b1}));
        i_bci_host_model.func(1, 12'h6AB, resp);
        chk(48'({sel_out_op, sel_out_new}), 48'h0);
        i_bci_host_model.func(1, 12'h5C3, resp);
        @(posedge mclk);
        #10;
        chk(48'({sel_in_op, sel_out_op, sel_out_new}), 48'({9'h012, 9'h1C3, 1'b0}));
    endtask : t_select

    task automatic t_sense();
        in_sense_cond  = 8'hA5;
        out_sense_cond = 8'h3C;
        for (int i = 0; i < 8; i++) begin
            i_bci_host_model.func(2, 12'h400 | 12'(i), resp);
            chk(48'(resp), 48'(in_sense_cond[i]));
            i_bci_host_model.func(3, 12'h400 | 12'(i), resp);
            chk(48'(resp), 48'(out_sense_cond[i]));
        end
        i_bci_host_model.func(2, 12'h408, resp);
        chk(48'(resp), 48'h0);
        i_bci_host_model.func(2, 12'h600, resp);
        chk(48'(resp), 48'h0);
    endtask : t_sense

    task automatic t_interrupt();
        pulse_done();
        chk(48'(interrupt), 48'h0);
        i_bci_host_model.func(0, 12'h404, resp);
        pulse_done();
        chk(48'(interrupt), 48'h1);
        i_bci_host_model.func(0, 12'h601, resp);
        chk(48'(interrupt), 48'h1);
        i_bci_host_model.func(0, 12'h401, resp);
        pulse_done();
        chk(48'(interrupt), 48'h0);
    endtask : t_interrupt

    task automatic t_input();
        fork
            i_bci_host_model.in_block(15'h0100, 2);
            begin
                feed(48'h0123456789AB, 8);
                feed(48'hFEDCBA987654, 8);
            end
        join
        chk(i_bci_host_model.got[0], 48'h0123456789AB);
        chk(i_bci_host_model.got[1], 48'hFEDCBA987654);
        fork
            i_bci_host_model.in_abort(10);
            feed(48'hFFFFFFFFFFFF, 3);
        join
        #200;
        chk(48'(in_data_ready), 48'h0);
        fork
            i_bci_host_model.in_block(15'h0200, 1);
            feed(48'h5A5A00C3C33F, 8);
        join
        chk(i_bci_host_model.got[2], 48'h5A5A00C3C33F);
    endtask : t_input

    task automatic t_output();
        fork
            begin
                i_bci_host_model.out_word(48'h13579BDF0246);
                chk(48'(out_data_resume), 48'h0);
            end
            drain(8, w);
        join
        chk(w, 48'h13579BDF0246);
        fork
            i_bci_host_model.out_word(48'hC0FFEE123456);
            drain(8, w);
        join
        chk(w, 48'hC0FFEE123456);
        fork
            i_bci_host_model.out_word(48'hABCDEF012345);
            drain(3, w);
        join
        i_bci_host_model.out_stop();
        @(posedge mclk);
        #10;
        chk(48'(char_out_valid), 48'h0);
    endtask : t_output

    //--------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------
    initial begin
        {mclk, rst_n, op_done, char_in_valid} = 4'h0;
        char_out_ready = 1'b1;
        {in_sense_cond, out_sense_cond} = 16'h0;
        char_in   = 6'h00;
        err_count = 0;
        cmp_count = 0;
        cyc       = 0;
        repeat (3) @(posedge mclk);
        #10;
        chk(48'({sense_response, interrupt, in_data_ready, out_data_resume, sel_in_op}), 48'h0);
        rst_n = 1'b1;
        t_sense();
        t_select();
        t_interrupt();
        t_input();
        t_output();
        tally_and_finish();
    end
endmodule : bci_equip_bench
`default_nettype wire
